// >>> design/bdr_bank.sv
/*
  Serial-bus register bank for a backlight driver: byte write and byte
  read transactions, three byte registers and the committed duty code.
  Assumes scl and sda come from pins asynchronous to mclk and that mclk
  is far faster than the bus clock; sda is open drain.
*/
// Contract
// - Each register is one byte, reached by byte read and byte write.
// - Undefined bit positions reset to zero.
// - Writing low brightness only stores it, the duty is unchanged.
// - Writing high brightness commits high byte and the low bits the mode uses at once.
// - In 8 bit mode the duty is brightness bits 11 to 4.
// - In 10 bit mode the duty is brightness bits 11 to 2.
// - In 12 bit mode the duty is all brightness bits 11 to 0.
// - Select bits 00, 01 and 10 pick 8, 10 and 12 bit resolution.
// - Phase shift is on exactly while its control bit is one.
// - Driver runs only while the backlight bit and enable pin are high.
// - Low register upper nibble holds bits 3 to 0, used in 10/12 bit.
// - Device answers address bytes 5A for write and 5B for read.
// - A write is address, index, data; data goes to the indexed register.
// - A read is address, index, repeated address, then returned data.
`timescale 1ns/1ns
module bdr_bank
  import bdr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        en_pin,
  output logic             sda_out,
  output logic             sda_oe,
  output logic [11:0]      dimming_duty,
  output logic [1:0]       dimming_mode,
  output logic             phase_shift_on,
  output logic             driver_enable
);
  logic [2:0] scl_s_q, scl_s_d, sda_s_q, sda_s_d;
  logic       en_s_q, en_r_q;
  bdr_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic       ack_q, ack_d, rd_q, rd_d, oe_q, oe_d, so_q, so_d;
  logic [7:0] idx_q, idx_d;
  logic [7:0] hi_q, hi_d, ctl_q, ctl_d, lo_q, lo_d;
  logic [11:0] duty_q, duty_d;
  logic [1:0]  mode_q, mode_d;
  logic        ps_q, ps_d, drv_q, drv_d;
  logic        scl_r, scl_f, start_c, stop_c, sda_v, scl_v;

  function automatic logic [7:0] reg_read(input logic [7:0] i,
      input logic [7:0] h, input logic [7:0] c, input logic [7:0] l);
    unique case (i)
      REG_BRT_HIGH: reg_read = h;
      REG_DEV_CTL:  reg_read = c & CTL_MASK;
      REG_BRT_LOW:  reg_read = l & LOW_MASK;
      default:      reg_read = 8'h00;
    endcase
  endfunction

  // Pin synchronisers, stage 0 read only by stage 1
  always_comb begin
    scl_s_d = {scl_s_q[1:0], scl_in};
    sda_s_d = {sda_s_q[1:0], sda_in};
  end
  assign scl_v   = scl_s_q[1];
  assign sda_v   = sda_s_q[1];
  assign scl_r   = scl_s_q[1] & ~scl_s_q[2];
  assign scl_f   = ~scl_s_q[1] & scl_s_q[2];
  assign start_c = scl_v & scl_s_q[2] & ~sda_v & sda_s_q[2];
  assign stop_c  = scl_v & scl_s_q[2] & sda_v & ~sda_s_q[2];

  // Serial protocol engine
  always_comb begin
    st_d  = st_q;
    sh_d  = sh_q;
    cnt_d = cnt_q;
    ack_d = ack_q;
    rd_d  = rd_q;
    oe_d  = oe_q;
    so_d  = so_q;
    idx_d = idx_q;
    hi_d  = hi_q;
    ctl_d = ctl_q;
    lo_d  = lo_q;
    if (start_c) begin
      st_d  = BDR_ADDR;
      cnt_d = 4'h0;
      ack_d = 1'b0;
      oe_d  = 1'b0;
    end else if (stop_c) begin
      st_d = BDR_IDLE;
      oe_d = 1'b0;
    end else if (st_q != BDR_IDLE && st_q != BDR_WAIT) begin
      if (scl_r && !ack_q && st_q != BDR_RDAT) begin
        sh_d  = {sh_q[6:0], sda_v};
        cnt_d = cnt_q + 4'h1;
      end else if (scl_r && st_q == BDR_RDAT && !ack_q) begin
        cnt_d = cnt_q + 4'h1;
      end else if (scl_r && ack_q && st_q == BDR_RDAT && !rd_q) begin
        if (sda_v) st_d = BDR_WAIT; // Master nack ends read
        else st_d = BDR_WAIT;       // One byte per read transaction
      end
      if (scl_f) begin
        if (ack_q) begin
          ack_d = 1'b0;
          cnt_d = 4'h0;
          oe_d  = 1'b0;
          if (st_q == BDR_RDAT) begin
            oe_d = ~sh_q[7] ? 1'b1 : 1'b0;
            so_d = 1'b0;
          end
        end else if (st_q == BDR_RDAT && cnt_q == 4'h8) begin
          ack_d = 1'b1;
          oe_d  = 1'b0;
        end else if (st_q == BDR_RDAT) begin
          sh_d = {sh_q[6:0], 1'b0};
          oe_d = ~sh_q[6];
          so_d = 1'b0;
        end else if (cnt_q == 4'h8) begin
          ack_d = 1'b1;
          oe_d  = 1'b1;
          so_d  = 1'b0;
          unique case (st_q)
            BDR_ADDR: begin
              if (sh_q[7:1] != SLAVE_ADDR) begin
                st_d = BDR_WAIT;
                ack_d = 1'b0;
                oe_d = 1'b0;
              end else if (sh_q[0]) begin
                st_d = BDR_RDAT;
                rd_d = 1'b1;
              end else begin
                st_d = BDR_INDX;
                rd_d = 1'b0;
              end
            end
            BDR_INDX: begin
              idx_d = sh_q;
              st_d  = BDR_WDAT;
            end
            BDR_WDAT: begin
              unique case (idx_q)
                REG_BRT_HIGH: hi_d = sh_q;
                REG_DEV_CTL:  ctl_d = sh_q & CTL_MASK;
                REG_BRT_LOW:  lo_d = sh_q & LOW_MASK;
                default: ;
              endcase
              st_d = BDR_WAIT;
            end
            default: st_d = BDR_WAIT;
          endcase
        end
      end
      // Load read data as the address ack completes
      if (scl_f && ack_q && st_q == BDR_RDAT && cnt_q == 4'h8 && rd_q) begin
        sh_d = reg_read(idx_q, hi_q, ctl_q, lo_q);
        oe_d = ~sh_d[7];
        so_d = 1'b0;
        cnt_d = 4'h0;
        rd_d = 1'b0;
      end
    end else if (st_q == BDR_WAIT) begin
      // Release the last ack even after the byte is done
      if (scl_f && ack_q) begin
        ack_d = 1'b0;
        oe_d  = 1'b0;
      end
    end
  end

  // Duty commit and control outputs
  always_comb begin
    duty_d = duty_q;
    if (st_q == BDR_WDAT && scl_f && !ack_q && cnt_q == 4'h8
        && idx_q == REG_BRT_HIGH) begin
      unique case (ctl_q[CTL_TWELVE_BIT:CTL_TEN_BIT])
        2'b01:   duty_d = {2'b00, sh_q, lo_q[7:6]};
        2'b10:   duty_d = {sh_q, lo_q[7:4]};
        default: duty_d = {4'h0, sh_q};
      endcase
    end
    mode_d = ctl_q[CTL_TWELVE_BIT:CTL_TEN_BIT];
    ps_d   = ctl_q[CTL_PHASE];
    drv_d  = ctl_q[CTL_BACKLIGHT] & en_r_q;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_s_q <= 3'b111;
      sda_s_q <= 3'b111;
      en_s_q  <= 1'b0;
      en_r_q  <= 1'b0;
      st_q    <= BDR_IDLE;
      sh_q    <= 8'h00;
      cnt_q   <= 4'h0;
      ack_q   <= 1'b0;
      rd_q    <= 1'b0;
      oe_q    <= 1'b0;
      so_q    <= 1'b0;
      idx_q   <= 8'h00;
      hi_q    <= RST_BRT_HIGH;
      ctl_q   <= RST_DEV_CTL;
      lo_q    <= RST_BRT_LOW;
      duty_q  <= {4'h0, RST_BRT_HIGH};
      mode_q  <= 2'b00;
      ps_q    <= 1'b0;
      drv_q   <= 1'b0;
    end else begin
      scl_s_q <= scl_s_d;
      sda_s_q <= sda_s_d;
      en_s_q  <= en_pin;
      en_r_q  <= en_s_q;
      st_q    <= st_d;
      sh_q    <= sh_d;
      cnt_q   <= cnt_d;
      ack_q   <= ack_d;
      rd_q    <= rd_d;
      oe_q    <= oe_d;
      so_q    <= so_d;
      idx_q   <= idx_d;
      hi_q    <= hi_d;
      ctl_q   <= ctl_d;
      lo_q    <= lo_d;
      duty_q  <= duty_d;
      mode_q  <= mode_d;
      ps_q    <= ps_d;
      drv_q   <= drv_d;
    end
  end

  assign sda_out        = so_q;
  assign sda_oe         = oe_q;
  assign dimming_duty   = duty_q;
  assign dimming_mode   = mode_q;
  assign phase_shift_on = ps_q;
  assign driver_enable  = drv_q;

  a_ctl_undef_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    ctl_q[7:4] == 4'h0) else $error("control upper bits not zero");
  a_low_undef_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    lo_q[3:0] == 4'h0) else $error("low register lower bits set");
  a_low_no_commit: assert property (@(posedge mclk) disable iff (sys_rst)
    (lo_q != $past(lo_q)) |-> duty_q == $past(duty_q))
    else $error("low write moved duty");
  a_duty_only_hi: assert property (@(posedge mclk) disable iff (sys_rst)
    (duty_q != $past(duty_q)) |-> $past(idx_q) == REG_BRT_HIGH)
    else $error("duty changed without high write");
  a_eight_bit_map: assert property (@(posedge mclk) disable iff (sys_rst)
    (duty_q != $past(duty_q) && $past(ctl_q[3:2]) == 2'b00)
    |-> duty_q[11:8] == 4'h0) else $error("8 bit duty too wide");
  a_ten_bit_map: assert property (@(posedge mclk) disable iff (sys_rst)
    (duty_q != $past(duty_q) && $past(ctl_q[3:2]) == 2'b01)
    |-> duty_q[1:0] == $past(lo_q[7:6])) else $error("10 bit low");
  a_twelve_map: assert property (@(posedge mclk) disable iff (sys_rst)
    (duty_q != $past(duty_q) && $past(ctl_q[3:2]) == 2'b10)
    |-> duty_q[3:0] == $past(lo_q[7:4])) else $error("12 bit low");
  a_mode_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 mode_q == $past(ctl_q[3:2])) else $error("mode lag");
  a_phase_follow: assert property (@(posedge mclk) disable iff (sys_rst)
    ##1 ps_q == $past(ctl_q[1])) else $error("phase bit lag");
  a_drv_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    driver_enable |-> $past(ctl_q[0]) && $past(en_r_q))
    else $error("driver on while gated");
  a_ack_release: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_q == BDR_WAIT && scl_f && ack_q) |=> !oe_q)
    else $error("ack not released");
  a_drive_low: assert property (@(posedge mclk) disable iff (sys_rst)
    sda_oe |-> !sda_out) else $error("sda driven high");
endmodule // bdr_bank

// >>> design/bdr_pkg.sv
/*
  Package for the backlight dimming register bank: register indices,
  reset values, field positions, bus address and serial states.
  Assumes a single system clock domain.
*/
package bdr_pkg;
  localparam logic [7:0] REG_BRT_HIGH = 8'h00;
  localparam logic [7:0] REG_DEV_CTL  = 8'h01;
  localparam logic [7:0] REG_BRT_LOW  = 8'h02;
  localparam logic [7:0] RST_BRT_HIGH = 8'hFF;
  localparam logic [7:0] RST_DEV_CTL  = 8'h00;
  localparam logic [7:0] RST_BRT_LOW  = 8'hF0;
  localparam logic [7:0] CTL_MASK     = 8'h0F;
  localparam logic [7:0] LOW_MASK     = 8'hF0;
  localparam int CTL_BACKLIGHT  = 0;
  localparam int CTL_PHASE      = 1;
  localparam int CTL_TEN_BIT    = 2;
  localparam int CTL_TWELVE_BIT = 3;
  localparam logic [6:0] SLAVE_ADDR = 7'h2D;
  typedef enum logic [2:0] {
    BDR_IDLE = 3'b000,
    BDR_ADDR = 3'b001,
    BDR_INDX = 3'b011,
    BDR_WDAT = 3'b010,
    BDR_RDAT = 3'b110,
    BDR_WAIT = 3'b111
  } bdr_state_t;
endpackage

// >>> dv/bdr_host.sv
/*
  Host master model for the bank's serial bus: byte write and byte read.
  Assumes a pull-up on sda and a free-running mclk.
*/
`timescale 1ns/1ns
module bdr_host (
  input  wire logic mclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic hp();
    repeat (8) @(posedge mclk);
    #1;
  endtask
  // Data moves only mid low phase
  task automatic bit_io(input logic b, output logic r);
    sda_pull = ~b;
    hp();
    scl = 1'b1;
    hp();
    r = sda;
    scl = 1'b0;
    hp();
  endtask
  task automatic start();
    sda_pull = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sda_pull = 1'b1;
    hp();
    scl = 1'b0;
    hp();
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sda_pull = 1'b0;
    hp();
  endtask
  // Ninth slot released, so a read byte ends in not-acknowledge
  task automatic byte_io(input logic [7:0] d, output logic [7:0] r,
                         output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(1'b1, a);
    ack = ~a;
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] idx,
                    input logic [7:0] v, output logic ok);
    logic [7:0] j;
    logic       a0, a1, a2;
    start();
    byte_io(adr, j, a0);
    byte_io(idx, j, a1);
    byte_io(v, j, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] v,
                    output logic ok);
    logic [7:0] j;
    logic       a0, a1, a2, a3;
    start();
    byte_io(8'h5A, j, a0);
    byte_io(idx, j, a1);
    start();
    byte_io(8'h5B, j, a2);
    byte_io(8'hFF, v, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule // bdr_host

// >>> dv/test_backlight_dimming_register_bank.sv
/*
  Self-checking bench: host model drives the bank, a register model
  predicts reads and the committed duty.  Assumes a pull-up on sda.
*/
`timescale 1ns/1ns
module test_backlight_dimming_register_bank;
  import bdr_pkg::*;
  logic        mclk, sys_rst, en_pin, scl, pull, sda, ok;
  logic        sda_out, sda_oe, phase_shift_on, driver_enable;
  logic [11:0] dimming_duty, duty;
  logic [1:0]  dimming_mode;
  logic [7:0]  hi, ctl, lo, rv;
  logic [31:0] seed;
  int          n_fail, total_checks;
  assign sda = ~pull & (sda_oe ? sda_out : 1'b1);
  bdr_bank u_bdr_bank (.mclk(mclk), .sys_rst(sys_rst), .scl_in(scl),
    .sda_in(sda), .en_pin(en_pin), .sda_out(sda_out), .sda_oe(sda_oe),
    .dimming_duty(dimming_duty), .dimming_mode(dimming_mode),
    .phase_shift_on(phase_shift_on), .driver_enable(driver_enable));
  bdr_host u_bdr_host (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(pull));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_reg(input logic [7:0] g, input logic [7:0] e);
    report({8'h00, g}, {8'h00, e});
  endtask
  task automatic chk_pin();
    report({dimming_mode, phase_shift_on, driver_enable, dimming_duty},
           {ctl[3:2], ctl[1], ctl[0] & en_pin, duty});
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
    u_bdr_host.rd(idx, rv, ok);
    chk_reg({7'h00, ok}, 8'h01);
    chk_reg(rv, e);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    u_bdr_host.wr(8'h5A, idx, v, ok);
    chk_reg({7'h00, ok}, 8'h01);
  endtask
  task automatic summarize();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    summarize();
  end
  initial begin
    sys_rst = 1'b1;
    en_pin = 1'b0;
    n_fail = 0;
    total_checks = 0;
    seed = 32'h5CE133A5;
    {hi, ctl, lo, duty} = {8'hFF, 8'h00, 8'hF0, 12'h0FF};
    repeat (20) @(posedge mclk);
    #1 sys_rst = 1'b0;
    chk_pin();
    rdchk(REG_BRT_HIGH, hi);
    rdchk(REG_DEV_CTL, ctl);
    rdchk(REG_BRT_LOW, lo);
    rdchk(8'h03, 8'h00);
    u_bdr_host.wr(8'h5C, REG_DEV_CTL, 8'h0F, ok);
    chk_reg({7'h00, ok}, 8'h00);
    rdchk(REG_DEV_CTL, ctl);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      en_pin = seed[8];
      wr(REG_DEV_CTL, {seed[7:4], 2'(i), seed[1:0]});
      ctl = {4'h0, 2'(i), seed[1:0]};
      wr(REG_BRT_LOW, seed[23:16]);
      lo = seed[23:16] & LOW_MASK;
      chk_pin();
      wr(REG_BRT_HIGH, seed[31:24]);
      hi = seed[31:24];
      case (ctl[3:2])
        2'b01: duty = {2'b00, hi, lo[7:6]};
        2'b10: duty = {hi, lo[7:4]};
        default: duty = {4'h0, hi};
      endcase
      chk_pin();
      rdchk(REG_BRT_HIGH, hi);
      rdchk(REG_DEV_CTL, ctl);
      rdchk(REG_BRT_LOW, lo);
    end
    summarize();
  end
endmodule // test_backlight_dimming_register_bank
